/* File: rtl/mie_defines.vh */
/*
  Constants for the instruction execute block: opcodes, register offsets,
  status bit positions, reset values and timing counts.
  Assumes it is included by its bare name from the design file.
*/
`ifndef MIE_DEFINES_VH
`define MIE_DEFINES_VH

// Instruction word fields
`define MIE_OP_HI        15
`define MIE_OP_LO        11
`define MIE_BIT_HI       10
`define MIE_BIT_LO       8
`define MIE_ADDR_HI      10

// Opcodes, five bits
`define MIE_OP_NOP       5'h00
`define MIE_OP_CLR       5'h01
`define MIE_OP_CLRB      5'h02
`define MIE_OP_CLRWDT    5'h03
`define MIE_OP_PRE1      5'h04
`define MIE_OP_PRE2      5'h05
`define MIE_OP_CPL       5'h06
`define MIE_OP_COMPLEMENT_TO_ACCUMULATOR      5'h07
`define MIE_OP_DAA       5'h08
`define MIE_OP_DEC       5'h09
`define MIE_OP_DECA      5'h0A
`define MIE_OP_INC       5'h0B
`define MIE_OP_INCA      5'h0C
`define MIE_OP_HALT      5'h0D
`define MIE_OP_JMP       5'h0E
`define MIE_OP_MOVAI     5'h0F
`define MIE_OP_MOVAM     5'h10
`define MIE_OP_MOVMA     5'h11
`define MIE_OP_ORAM      5'h12
`define MIE_OP_ORAI      5'h13
`define MIE_OP_ORM       5'h14
`define MIE_OP_RET       5'h15
`define MIE_OP_RETAI     5'h16
`define MIE_OP_RETURN_FROM_INTERRUPT      5'h17
`define MIE_OP_RL        5'h18
`define MIE_OP_CALL      5'h19

// Data memory address that aliases the low program counter byte
`define MIE_PCL_ADDR     8'h02

// Register port offsets; 8'h00..8'h7F is data memory
`define MIE_REG_ACC      8'h80
`define MIE_REG_STATUS   8'h81
`define MIE_REG_PCL      8'h82
`define MIE_REG_PCH      8'h83
`define MIE_REG_WDT      8'h84
`define MIE_REG_CTRL     8'h85

// Status bit positions
`define MIE_ST_C         0
`define MIE_ST_AC        1
`define MIE_ST_Z         2
`define MIE_ST_OV        3
`define MIE_ST_PDF       4
`define MIE_ST_TO        5

// Control bit positions
`define MIE_CTRL_GIE     0
`define MIE_CTRL_HALT    1

// Reset values
`define MIE_RST_BYTE     8'h00
`define MIE_RST_PC       11'h000

// Timing: system clocks per instruction cycle, last phase index
`define MIE_CLK_PER_CYC  4
`define MIE_PH_LAST      2'h3

// Decimal adjust constants
`define MIE_BCD_MAX      4'h9
`define MIE_BCD_ADJ      4'h6

`endif

/* File: rtl/mie_execute.v */
/*
  Execute unit for an 8-bit microcontroller subset: memory and bit clear,
  watchdog clear and pre-clear, complement, decimal adjust, increment,
  decrement, halt, jump, call, moves, no-op, OR, returns and rotate left.
  Assumes a single 50 MHz clock, an instruction source that waits for
  ready_o, and a register port master with one-cycle strobes.
*/
// Our own choices: the address-and-strobe port and the register addresses.
// Operation
// RL1 - Clearing a memory byte writes zero and keeps every flag.
// RL2 - Bit clear zeroes only the chosen bit, flags untouched.
// RL3 - Watchdog clear zeroes the count, power down and timeout flags.
// RL4 - Watchdog clears only after both pre-clear instructions have run.
// RL5 - A lone pre-clear only records itself; count and flags stay.
// RL6 - Memory complement inverts in place, only zero flag changes.
// RL7 - Accumulator complement inverts into accumulator, memory kept, zero flag only.
// RL8 - Low nibble gets plus six when above nine or half carry set.
// RL9 - High nibble plus nibble carry adjusted likewise, sets carry, result to memory.
// RL10 - Decrement in place or into accumulator, only zero flag.
// RL11 - Increment in place or into accumulator, only zero flag.
// RL12 - Halt stops, clears watchdog and prescaler, power down set, timeout cleared.
// RL13 - Jump loads the program counter from the instruction, no flags.
// RL14 - Immediate move loads the constant into accumulator, no flags.
// RL15 - Moves between accumulator and memory copy unchanged, no flags.
// RL16 - No-op only advances the program counter.
// RL17 - OR into accumulator or memory, only zero flag changes.
// RL18 - Return pops the program counter, two cycles, no flags.
// RL19 - Return with value pops counter and loads immediate into accumulator.
// RL20 - Interrupt return pops counter and sets global interrupt enable.
// RL21 - Rotate left moves bit seven into bit zero.
// RL22 - Writing the low program counter byte costs one extra cycle.
// RL23 - Zero flag set when the byte result is zero, else cleared.
`timescale 1ns/1ns
`include "mie_defines.vh"

module mie_execute #(
  parameter MEM_DEPTH   = 128,
  parameter MEM_AW      = 7,
  parameter STACK_DEPTH = 4,
  parameter SP_W        = 2,
  parameter WDT_PRE_W   = 8
) (
  input  wire        ref_clk_i,
  input  wire        reset_n_i,
  input  wire [15:0] instr_i,
  input  wire        instr_valid_i,
  input  wire        wake_i,
  input  wire [7:0]  reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [7:0]  reg_rdata_o,
  output reg         ready_o,
  output reg         done_o,
  output reg         halted_o,
  output reg         wdt_timeout_o,
  output reg         gie_o
);

  localparam ST_IDLE = 2'b00;
  localparam ST_EXEC = 2'b01;
  localparam ST_HALT = 2'b10;

  reg               rst_meta_q;
  reg               rst_n_q;
  reg  [1:0]        state_q;
  reg  [1:0]        ph_q;
  reg  [1:0]        cyc_q;
  reg  [1:0]        extra_q;
  reg  [15:0]       ir_q;
  reg  [7:0]        acc_q;
  reg  [7:0]        status_q;
  reg  [10:0]       pc_q;
  reg  [7:0]        mem_q [0:MEM_DEPTH-1];
  reg  [10:0]       stk_q [0:STACK_DEPTH-1];
  reg  [SP_W-1:0]   sp_q;
  reg               pre1_q;
  reg               pre2_q;
  reg  [1:0]        div_q;
  reg  [WDT_PRE_W-1:0] wpre_q;
  reg  [7:0]        wdt_q;

  // Decode fields of the held instruction
  wire [4:0]        op    = ir_q[`MIE_OP_HI:`MIE_OP_LO];
  wire [2:0]        bsel  = ir_q[`MIE_BIT_HI:`MIE_BIT_LO];
  wire [7:0]        opnd  = ir_q[7:0];
  wire [10:0]       jaddr = ir_q[`MIE_ADDR_HI:0];
  wire              is_pcl = (opnd == `MIE_PCL_ADDR);
  wire [7:0]        m_rd  = is_pcl ? pc_q[7:0] : mem_q[opnd[MEM_AW-1:0]];
  wire [10:0]       pc_inc = pc_q + 11'h001;
  wire [SP_W-1:0]   sp_dec = sp_q - {{(SP_W-1){1'b0}}, 1'b1};
  wire              commit = (state_q == ST_EXEC) && (ph_q == `MIE_PH_LAST)
                             && (cyc_q == 2'h0);
  wire              tick   = (div_q == `MIE_PH_LAST);

  // Reset release through two flip-flops
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Result datapath for the held instruction
  reg  [7:0]  res;
  reg         wr_m;
  reg         wr_a;
  reg         upd_z;
  reg         c_nx;
  reg  [10:0] pc_nx;
  reg         push;
  reg         pop;
  reg         wclr;
  reg         halt_go;
  reg         gie_set;
  reg  [1:0]  extra_d;
  reg         adj_lo;
  reg         nib_c;
  reg  [3:0]  lo_res;
  reg  [4:0]  hi_sum;
  reg         adj_hi;
  reg  [3:0]  hi_res;

  always @* begin
    res     = 8'h00;
    wr_m    = 1'b0;
    wr_a    = 1'b0;
    upd_z   = 1'b0;
    c_nx    = status_q[`MIE_ST_C];
    pc_nx   = pc_inc;
    push    = 1'b0;
    pop     = 1'b0;
    wclr    = 1'b0;
    halt_go = 1'b0;
    gie_set = 1'b0;
    extra_d = 2'h0;
    adj_lo  = (acc_q[3:0] > `MIE_BCD_MAX) || status_q[`MIE_ST_AC];
    nib_c   = adj_lo & ~status_q[`MIE_ST_AC];                  // see RL8
    lo_res  = adj_lo ? (acc_q[3:0] + `MIE_BCD_ADJ) : acc_q[3:0]; // see RL8
    hi_sum  = {1'b0, acc_q[7:4]} + {4'h0, nib_c};
    adj_hi  = (hi_sum > {1'b0, `MIE_BCD_MAX}) || status_q[`MIE_ST_C];
    hi_res  = adj_hi ? (hi_sum[3:0] + `MIE_BCD_ADJ) : hi_sum[3:0]; // see RL9
    case (op)
      `MIE_OP_CLR: begin
        res  = 8'h00;                                          // see RL1
        wr_m = 1'b1;
      end
      `MIE_OP_CLRB: begin
        res  = m_rd & ~(8'h01 << bsel);                        // see RL2
        wr_m = 1'b1;
      end
      `MIE_OP_CLRWDT: wclr = 1'b1;                             // see RL3
      `MIE_OP_CPL: begin
        res   = ~m_rd;                                         // see RL6
        wr_m  = 1'b1;
        upd_z = 1'b1;
      end
      `MIE_OP_COMPLEMENT_TO_ACCUMULATOR: begin
        res   = ~m_rd;                                         // see RL7
        wr_a  = 1'b1;
        upd_z = 1'b1;
      end
      `MIE_OP_DAA: begin
        res  = {hi_res, lo_res};                               // see RL9
        wr_m = 1'b1;
        c_nx = adj_hi | status_q[`MIE_ST_C];                   // see RL9
      end
      `MIE_OP_DEC, `MIE_OP_DECA: begin
        res   = m_rd - 8'h01;                                  // see RL10
        wr_m  = (op == `MIE_OP_DEC);
        wr_a  = (op == `MIE_OP_DECA);
        upd_z = 1'b1;
      end
      `MIE_OP_INC, `MIE_OP_INCA: begin
        res   = m_rd + 8'h01;                                  // see RL11
        wr_m  = (op == `MIE_OP_INC);
        wr_a  = (op == `MIE_OP_INCA);
        upd_z = 1'b1;
      end
      `MIE_OP_HALT: halt_go = 1'b1;                            // see RL12
      `MIE_OP_JMP: pc_nx = jaddr;                              // see RL13
      `MIE_OP_MOVAI: begin
        res  = opnd;                                           // see RL14
        wr_a = 1'b1;
      end
      `MIE_OP_MOVAM: begin
        res  = m_rd;                                           // see RL15
        wr_a = 1'b1;
      end
      `MIE_OP_MOVMA: begin
        res  = acc_q;                                          // see RL15
        wr_m = 1'b1;
      end
      `MIE_OP_ORAM, `MIE_OP_ORM: begin
        res   = acc_q | m_rd;                                  // see RL17
        wr_a  = (op == `MIE_OP_ORAM);
        wr_m  = (op == `MIE_OP_ORM);
        upd_z = 1'b1;
      end
      `MIE_OP_ORAI: begin
        res   = acc_q | opnd;                                  // see RL17
        wr_a  = 1'b1;
        upd_z = 1'b1;
      end
      `MIE_OP_RET, `MIE_OP_RETAI, `MIE_OP_RETURN_FROM_INTERRUPT: begin
        pop     = 1'b1;
        pc_nx   = stk_q[sp_dec];                               // see RL18
        extra_d = 2'h1;                                        // see RL18
        res     = opnd;                                        // see RL19
        wr_a    = (op == `MIE_OP_RETAI);                       // see RL19
        gie_set = (op == `MIE_OP_RETURN_FROM_INTERRUPT);                        // see RL20
      end
      `MIE_OP_RL: begin
        res  = {m_rd[6:0], m_rd[7]};                           // see RL21
        wr_m = 1'b1;
      end
      `MIE_OP_CALL: begin
        push    = 1'b1;
        pc_nx   = jaddr;
        extra_d = 2'h1;
      end
      default: res = 8'h00;                                    // see RL16
    endcase
    // A result landing in the low counter byte redirects the fetch
    if (wr_m && is_pcl) begin
      pc_nx   = {pc_q[10:8], res};
      extra_d = 2'h1;                                          // see RL22
    end
  end

  // Sequencer: one instruction cycle is four clocks
  always @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q  <= ST_IDLE;
      ph_q     <= 2'h0;
      cyc_q    <= 2'h0;
      extra_q  <= 2'h0;
      ir_q     <= 16'h0000;
      ready_o  <= 1'b0;
      done_o   <= 1'b0;
      halted_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          ready_o <= 1'b1;
          if (ready_o && instr_valid_i) begin
            ir_q    <= instr_i;
            ready_o <= 1'b0;
            ph_q    <= 2'h0;
            cyc_q   <= 2'h0;
            state_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          ph_q <= ph_q + 2'h1;
          if (ph_q == `MIE_PH_LAST) begin
            if (commit) begin
              extra_q <= extra_d;
            end
            if ((commit && extra_d == 2'h0) || (!commit && cyc_q == extra_q)) begin
              done_o <= 1'b1;
              if (op == `MIE_OP_HALT) begin
                state_q  <= ST_HALT;                           // see RL12
                halted_o <= 1'b1;
              end else begin
                state_q <= ST_IDLE;
                ready_o <= 1'b1;
              end
            end else begin
              cyc_q <= cyc_q + 2'h1;
            end
          end
        end
        ST_HALT: begin
          // Timeout or an outside wake ends power down
          if (wake_i || wdt_timeout_o) begin
            halted_o <= 1'b0;
            state_q  <= ST_IDLE;
            ready_o  <= 1'b1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Data memory; an instruction commit wins over a port write
  integer k;
  always @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (k = 0; k < MEM_DEPTH; k = k + 1) begin
        mem_q[k] <= `MIE_RST_BYTE;
      end
    end else if (commit && wr_m && !is_pcl) begin
      mem_q[opnd[MEM_AW-1:0]] <= res;                          // see RL1
    end else if (reg_wr_i && !reg_addr_i[7] && reg_addr_i != `MIE_PCL_ADDR) begin
      mem_q[reg_addr_i[MEM_AW-1:0]] <= reg_wdata_i;
    end
  end

  // Return stack, four levels, wraps silently on overflow
  integer j;
  always @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sp_q <= {SP_W{1'b0}};
      for (j = 0; j < STACK_DEPTH; j = j + 1) begin
        stk_q[j] <= `MIE_RST_PC;
      end
    end else if (commit && push) begin
      stk_q[sp_q] <= pc_inc;
      sp_q        <= sp_q + {{(SP_W-1){1'b0}}, 1'b1};
    end else if (commit && pop) begin
      sp_q <= sp_dec;                                          // see RL18
    end
  end

  // Accumulator, status, program counter and interrupt enable
  always @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      acc_q    <= `MIE_RST_BYTE;
      status_q <= `MIE_RST_BYTE;
      pc_q     <= `MIE_RST_PC;
      gie_o    <= 1'b0;
    end else begin
      if (commit) begin
        pc_q <= pc_nx;                                         // see RL16
        if (wr_a) begin
          acc_q <= res;                                        // see RL15
        end
        if (upd_z) begin
          status_q[`MIE_ST_Z] <= (res == 8'h00);               // see RL23
        end
        status_q[`MIE_ST_C] <= c_nx;
        if (gie_set) begin
          gie_o <= 1'b1;                                       // see RL20
        end
      end else if (reg_wr_i) begin
        case (reg_addr_i)
          `MIE_REG_ACC:    acc_q <= reg_wdata_i;
          `MIE_REG_STATUS: status_q[3:0] <= reg_wdata_i[3:0];
          `MIE_REG_PCL, `MIE_PCL_ADDR: pc_q[7:0] <= reg_wdata_i;
          `MIE_REG_PCH:    pc_q[10:8] <= reg_wdata_i[2:0];
          `MIE_REG_CTRL:   gie_o <= reg_wdata_i[`MIE_CTRL_GIE];
          default:         acc_q <= acc_q;
        endcase
      end
      // Flag clears first so that a timeout in the same cycle still lands
      if (commit && (wclr || (pre1_q && op == `MIE_OP_PRE2)
                           || (pre2_q && op == `MIE_OP_PRE1))) begin
        status_q[`MIE_ST_PDF] <= 1'b0;                         // see RL4
        status_q[`MIE_ST_TO]  <= 1'b0;                         // see RL3
      end
      if (commit && halt_go) begin
        status_q[`MIE_ST_PDF] <= 1'b1;                         // see RL12
        status_q[`MIE_ST_TO]  <= 1'b0;                         // see RL12
      end
      if (tick && wdt_q == 8'hFF && wpre_q == {WDT_PRE_W{1'b1}}) begin
        status_q[`MIE_ST_TO] <= 1'b1;
      end
    end
  end

  // Watchdog: prescaler advances once per instruction cycle, count once per prescaler wrap
  wire pair_done = commit && ((pre1_q && op == `MIE_OP_PRE2) ||
                              (pre2_q && op == `MIE_OP_PRE1));
  always @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      div_q         <= 2'h0;
      wpre_q        <= {WDT_PRE_W{1'b0}};
      wdt_q         <= `MIE_RST_BYTE;
      pre1_q        <= 1'b0;
      pre2_q        <= 1'b0;
      wdt_timeout_o <= 1'b0;
    end else begin
      div_q         <= div_q + 2'h1;
      // Overflow reports even when a clear lands in the same cycle, as the flag does
      wdt_timeout_o <= tick && (wdt_q == 8'hFF) && (wpre_q == {WDT_PRE_W{1'b1}});
      if (commit && (wclr || pair_done || halt_go)) begin
        wdt_q  <= `MIE_RST_BYTE;                               // see RL3
        wpre_q <= {WDT_PRE_W{1'b0}};                           // see RL12
        pre1_q <= 1'b0;
        pre2_q <= 1'b0;
      end else begin
        if (commit && op == `MIE_OP_PRE1) begin
          pre1_q <= 1'b1;                                      // see RL5
        end
        if (commit && op == `MIE_OP_PRE2) begin
          pre2_q <= 1'b1;                                      // see RL5
        end
        if (tick) begin
          wpre_q <= wpre_q + {{(WDT_PRE_W-1){1'b0}}, 1'b1};
          if (wpre_q == {WDT_PRE_W{1'b1}}) begin
            wdt_q <= wdt_q + 8'h01;
          end
        end
      end
    end
  end

  // Register port read data, valid the cycle after the strobe
  always @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `MIE_REG_ACC:    reg_rdata_o <= acc_q;
        `MIE_REG_STATUS: reg_rdata_o <= {2'b00, status_q[5:0]};
        `MIE_REG_PCL, `MIE_PCL_ADDR: reg_rdata_o <= pc_q[7:0];
        `MIE_REG_PCH:    reg_rdata_o <= {5'h00, pc_q[10:8]};
        `MIE_REG_WDT:    reg_rdata_o <= wdt_q;
        `MIE_REG_CTRL:   reg_rdata_o <= {6'h00, halted_o, gie_o};
        default: begin
          reg_rdata_o <= reg_addr_i[7] ? 8'h00 : mem_q[reg_addr_i[MEM_AW-1:0]];
        end
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

endmodule // mie_execute

/* File: test/mie_execute_sva.sv */
/*
  Checker for the execute block: instruction timing, halt entry and hold,
  interrupt enable on return.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ns
`include "mie_defines.vh"

module mie_execute_sva (
  input wire logic        ref_clk_i,
  input wire logic        reset_n_i,
  input wire logic [15:0] instr_i,
  input wire logic        instr_valid_i,
  input wire logic        wake_i,
  input wire logic        ready_o,
  input wire logic        done_o,
  input wire logic        halted_o,
  input wire logic        wdt_timeout_o,
  input wire logic        gie_o
);
  // Decode of the word offered on a taking edge
  wire [4:0] op_w   = instr_i[`MIE_OP_HI:`MIE_OP_LO];
  wire       take_w = ready_o && instr_valid_i;
  wire       pcl_w  = instr_i[7:0] == `MIE_PCL_ADDR;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_nop_timing: assert property (
    take_w && op_w == `MIE_OP_NOP |=> !ready_o [*4] ##1 (done_o && ready_o))
    else $error("no-op did not finish after four cycles");
  a_clr_timing: assert property (
    take_w && op_w == `MIE_OP_CLR && !pcl_w |-> ##5 done_o)
    else $error("memory clear did not finish after four cycles");
  a_jump_timing: assert property (
    take_w && op_w == `MIE_OP_JMP |-> ##5 done_o)
    else $error("jump did not finish after four cycles");
  a_ret_two_cycles: assert property (
    take_w && op_w == `MIE_OP_RET |=> !done_o [*8] ##1 done_o)
    else $error("return did not take two instruction cycles");
  a_retval_two_cycles: assert property (
    take_w && op_w == `MIE_OP_RETAI |=> !ready_o [*8] ##1 ready_o)
    else $error("return with value did not take two instruction cycles");
  a_return_from_interrupt_sets_gie: assert property (
    take_w && op_w == `MIE_OP_RETURN_FROM_INTERRUPT |-> ##9 (done_o && gie_o))
    else $error("interrupt return did not set the enable");
  a_pcl_write_extra: assert property (
    take_w && pcl_w && (op_w == `MIE_OP_MOVMA || op_w == `MIE_OP_CLR)
    |-> ##5 !done_o ##4 done_o)
    else $error("write to program counter low lacked the extra cycle");
  a_halt_entry: assert property (
    take_w && op_w == `MIE_OP_HALT |-> ##5 (done_o && halted_o && !ready_o))
    else $error("halt did not stop execution");
  a_halt_hold: assert property (
    halted_o && !ready_o && !wake_i && !wdt_timeout_o |=> !ready_o || wdt_timeout_o)
    else $error("halted core became ready without a wake cause");

  // Main scenarios reached
  c_wake: cover property (halted_o && wake_i);
  c_timeout: cover property (wdt_timeout_o);
  c_return_from_interrupt: cover property (take_w && op_w == `MIE_OP_RETURN_FROM_INTERRUPT);
endmodule // mie_execute_sva

bind mie_execute mie_execute_sva u_sva (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .instr_i(instr_i),
  .instr_valid_i(instr_valid_i), .wake_i(wake_i), .ready_o(ready_o),
  .done_o(done_o), .halted_o(halted_o), .wdt_timeout_o(wdt_timeout_o),
  .gie_o(gie_o)
);

/* File: test/mie_execute_tb_top.sv */
/*
  Self-checking bench for the execute block: instructions and register
  port accesses with expected values.
  Assumes a short watchdog prescaler so a time-out fits in the run.
*/
`timescale 1ns/1ns
`include "mie_defines.vh"

module mie_execute_tb_top;
  logic        ref_clk_i     = 1'b0;
  logic        reset_n_i     = 1'b0;
  logic [15:0] instr_i       = 16'h0000;
  logic        instr_valid_i = 1'b0;
  logic        wake_i        = 1'b0;
  logic [7:0]  reg_addr_i    = 8'h00;
  logic [7:0]  reg_wdata_i   = 8'h00;
  logic        reg_wr_i      = 1'b0;
  logic        reg_rd_i      = 1'b0;
  wire  [7:0]  reg_rdata_o;
  wire         ready_o, done_o, halted_o, wdt_timeout_o, gie_o;
  int          fail_count    = 0;
  int          compares      = 0;
  int          i, n;
  // Decimal adjust cases: accumulator, status in, memory out, status out
  logic [7:0]  daa_acc [4]   = '{8'h9A, 8'h15, 8'h25, 8'h34};
  logic [7:0]  daa_sti [4]   = '{8'h08, 8'h0A, 8'h09, 8'h08};
  logic [7:0]  daa_mem [4]   = '{8'h00, 8'h1B, 8'h85, 8'h34};
  logic [7:0]  daa_sto [4]   = '{8'h09, 8'h0A, 8'h09, 8'h08};

  // 50 MHz clock
  always #10 ref_clk_i = ~ref_clk_i;

  // Short prescaler keeps a watchdog overflow near four thousand clocks
  mie_execute #(.WDT_PRE_W(2)) u_dut (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .instr_i(instr_i),
    .instr_valid_i(instr_valid_i), .wake_i(wake_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .ready_o(ready_o), .done_o(done_o),
    .halted_o(halted_o), .wdt_timeout_o(wdt_timeout_o), .gie_o(gie_o));

  // Step past an edge so registered outputs have settled
  task automatic tick();
    @(posedge ref_clk_i);
    #1;
  endtask

  task automatic chk8(input logic [7:0] act, input logic [7:0] exp);
    compares++;
    if (act !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, act, exp);
    end
  endtask

  // Extra idle cycle after each strobe so no signal is set twice at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    tick();
    reg_wr_i <= 1'b0;
    tick();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    tick();
    reg_rd_i <= 1'b0;
    chk8(reg_rdata_o, e);
    tick();
  endtask

  task automatic wait_rdy();
    int k;
    k = 0;
    while (ready_o !== 1'b1 && k < 50) begin
      tick();
      k++;
    end
  endtask

  // Issue one instruction and check its length in clocks
  task automatic ex(input logic [4:0] op, input logic [10:0] arg, input logic [7:0] cyc);
    int k;
    wait_rdy();
    instr_i <= {op, arg};
    instr_valid_i <= 1'b1;
    tick();
    instr_valid_i <= 1'b0;
    k = 0;
    while (done_o !== 1'b1 && k < 20) begin
      tick();
      k++;
    end
    chk8(8'(k), cyc);
  endtask

  task automatic op_chk(input logic [4:0] op, input logic [10:0] arg, input logic [7:0] cyc,
                        input logic [7:0] ra, input logic [7:0] rv, input logic [7:0] st);
    ex(op, arg, cyc);
    rd(ra, rv);
    rd(`MIE_REG_STATUS, st);
  endtask

  task automatic wake();
    wake_i <= 1'b1;
    tick();
    wait_rdy();
    wake_i <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Hang guard, well beyond the expected run of some five thousand clocks
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fail_count++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    // First access only once the internal reset copy has let go
    wait_rdy();
    rd(`MIE_REG_ACC, 8'h00);
    wr(8'hF0, 8'h5A);
    rd(8'hF0, 8'h00);
    wr(8'h10, 8'hA5);
    wr(`MIE_REG_STATUS, 8'h0B);
    op_chk(`MIE_OP_CLR, 11'h10, 4, 8'h10, 8'h00, 8'h0B);
    wr(8'h11, 8'hFF);
    wr(`MIE_REG_STATUS, 8'h0F);
    op_chk(`MIE_OP_CLRB, 11'h511, 4, 8'h11, 8'hDF, 8'h0F);
    wr(8'h12, 8'hFF);
    wr(`MIE_REG_STATUS, 8'h0B);
    op_chk(`MIE_OP_CPL, 11'h12, 4, 8'h12, 8'h00, 8'h0F);
    op_chk(`MIE_OP_CPL, 11'h12, 4, 8'h12, 8'hFF, 8'h0B);
    wr(8'h13, 8'h0F);
    op_chk(`MIE_OP_COMPLEMENT_TO_ACCUMULATOR, 11'h13, 4, `MIE_REG_ACC, 8'hF0, 8'h0B);
    rd(8'h13, 8'h0F);
    wr(8'h14, 8'h01);
    op_chk(`MIE_OP_DEC, 11'h14, 4, 8'h14, 8'h00, 8'h0F);
    op_chk(`MIE_OP_DECA, 11'h14, 4, `MIE_REG_ACC, 8'hFF, 8'h0B);
    rd(8'h14, 8'h00);
    wr(8'h15, 8'hFF);
    op_chk(`MIE_OP_INC, 11'h15, 4, 8'h15, 8'h00, 8'h0F);
    op_chk(`MIE_OP_INCA, 11'h15, 4, `MIE_REG_ACC, 8'h01, 8'h0B);
    op_chk(`MIE_OP_MOVAI, 11'h3C, 4, `MIE_REG_ACC, 8'h3C, 8'h0B);
    op_chk(`MIE_OP_MOVMA, 11'h16, 4, 8'h16, 8'h3C, 8'h0B);
    wr(8'h17, 8'h81);
    op_chk(`MIE_OP_MOVAM, 11'h17, 4, `MIE_REG_ACC, 8'h81, 8'h0B);
    wr(8'h18, 8'h42);
    op_chk(`MIE_OP_ORAM, 11'h18, 4, `MIE_REG_ACC, 8'hC3, 8'h0B);
    wr(8'h19, 8'h0C);
    op_chk(`MIE_OP_ORM, 11'h19, 4, 8'h19, 8'hCF, 8'h0B);
    op_chk(`MIE_OP_MOVAI, 11'h00, 4, `MIE_REG_ACC, 8'h00, 8'h0B);
    op_chk(`MIE_OP_ORAI, 11'h00, 4, `MIE_REG_ACC, 8'h00, 8'h0F);
    wr(8'h1A, 8'h81);
    op_chk(`MIE_OP_RL, 11'h1A, 4, 8'h1A, 8'h03, 8'h0F);
    // Both nibble adjusts, each carry source, and the untouched case
    for (i = 0; i < 4; i++) begin
      wr(`MIE_REG_ACC, daa_acc[i]);
      wr(`MIE_REG_STATUS, daa_sti[i]);
      op_chk(`MIE_OP_DAA, 11'h1B, 4, 8'h1B, daa_mem[i], daa_sto[i]);
    end
    op_chk(`MIE_OP_JMP, 11'h5A5, 4, `MIE_REG_PCL, 8'hA5, 8'h08);
    rd(`MIE_REG_PCH, 8'h05);
    op_chk(`MIE_OP_NOP, 11'h000, 4, `MIE_REG_PCL, 8'hA6, 8'h08);
    ex(`MIE_OP_CALL, 11'h123, 8);
    op_chk(`MIE_OP_RET, 11'h000, 8, `MIE_REG_PCL, 8'hA7, 8'h08);
    ex(`MIE_OP_CALL, 11'h123, 8);
    op_chk(`MIE_OP_RETAI, 11'h077, 8, `MIE_REG_ACC, 8'h77, 8'h08);
    rd(`MIE_REG_PCL, 8'hA8);
    ex(`MIE_OP_CALL, 11'h123, 8);
    op_chk(`MIE_OP_RETURN_FROM_INTERRUPT, 11'h000, 8, `MIE_REG_CTRL, 8'h01, 8'h08);
    ex(`MIE_OP_MOVAI, 11'h040, 4);
    op_chk(`MIE_OP_MOVMA, 11'h002, 8, `MIE_REG_PCL, 8'h40, 8'h08);
    op_chk(`MIE_OP_CLR, 11'h002, 8, `MIE_REG_PCL, 8'h00, 8'h08);
    // Halt, then the pre-clear pair, the plain clear and a time-out
    wr(`MIE_REG_STATUS, 8'h00);
    op_chk(`MIE_OP_HALT, 11'h000, 4, `MIE_REG_PCL, 8'h01, 8'h10);
    wake();
    op_chk(`MIE_OP_PRE1, 11'h000, 4, `MIE_REG_ACC, 8'h40, 8'h10);
    op_chk(`MIE_OP_PRE1, 11'h000, 4, `MIE_REG_ACC, 8'h40, 8'h10);
    op_chk(`MIE_OP_PRE2, 11'h000, 4, `MIE_REG_WDT, 8'h00, 8'h00);
    ex(`MIE_OP_HALT, 11'h000, 4);
    wake();
    op_chk(`MIE_OP_CLRWDT, 11'h000, 4, `MIE_REG_WDT, 8'h00, 8'h00);
    ex(`MIE_OP_HALT, 11'h000, 4);
    n = 0;
    while (wdt_timeout_o !== 1'b1 && n < 6000) begin
      tick();
      n++;
    end
    chk8({7'h00, wdt_timeout_o}, 8'h01);
    wait_rdy();
    rd(`MIE_REG_STATUS, 8'h30);
    op_chk(`MIE_OP_CLRWDT, 11'h000, 4, `MIE_REG_WDT, 8'h00, 8'h00);
    tally_and_finish();
  end
endmodule // mie_execute_tb_top
